/* File: verilog/hds_pkg.sv */
`default_nettype none
package hds_pkg;
  // bit timing
  localparam int unsigned INPUT_CLOCK_HZ = 20_000_000;
  localparam int unsigned BIT_RATE       = 9_600;
  localparam logic [11:0] BIT_CYCLES     = 12'(INPUT_CLOCK_HZ / BIT_RATE);
  localparam logic [11:0] HALF_CYCLES    = 12'(INPUT_CLOCK_HZ / BIT_RATE / 2);
  localparam logic [7:0]  EDGE_PRELOAD   = 8'hFF;

  // register byte addresses
  localparam logic [7:0] ADDR_STATE   = 8'h00;
  localparam logic [7:0] ADDR_TXHOLD  = 8'h04;
  localparam logic [7:0] ADDR_RXHOLD  = 8'h08;
  localparam logic [7:0] ADDR_COMMAND = 8'h0C;
  localparam logic [7:0] ADDR_CONFIG  = 8'h10;

  // serial_state_control bit positions
  localparam int ST_TX_ACTIVE  = 0;
  localparam int ST_TX_ALLOW   = 1;
  localparam int ST_RX_ACTIVE  = 2;
  localparam int ST_RX_PENDING = 3;
  localparam int ST_PARITY     = 4;
  localparam int ST_FRAMING    = 5;
  localparam int ST_NINTH      = 7;

  // command and config fields
  localparam int CMD_SEND      = 0;
  localparam int CMD_RECEIVE   = 1;
  localparam int CFG_WIDTH_LSB = 0;
  localparam int CFG_PARITY_ON = 4;
  localparam int CFG_ODD       = 5;
  localparam int CFG_FLOW      = 6;
  localparam int CFG_STOP_LSB  = 8;

  // reset values
  localparam logic [3:0]  WIDTH_RESET = 4'h8;
  localparam logic [1:0]  STOP_COUNT  = 2'h1;
  localparam logic [7:0]  BYTE_RESET  = 8'h00;
  localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_CTS  = 5'b00010,
    S_TX   = 5'b00100,
    S_ARM  = 5'b01000,
    S_RX   = 5'b10000
  } hds_state_e;

  // parity over the low width bits; odd selects the inverted sense
  function automatic logic hds_parity(input logic [7:0] data, input logic [3:0] width,
                                      input logic odd);
    logic [7:0] mask;
    mask = 8'(9'h1FF >> (4'd9 - width));
    return odd ^ (^(data & mask));
  endfunction
endpackage
`default_nettype wire

/* File: verilog/hds_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module hds_sync (
  input  wire logic clock, // system clock
  input  wire logic nrst,  // sync reset, low active
  input  wire logic pin,   // asynchronous pin
  output logic      level  // filtered level
);
  logic s1;
  logic s2;
  logic s3;

  // three stages; level moves only once stages two and three agree
  always_ff @(posedge clock) begin
    if (!nrst) begin
      s1    <= 1'b1;
      s2    <= 1'b1;
      s3    <= 1'b1;
      level <= 1'b1;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verilog/hds_bit_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module hds_bit_timer (
  input  wire logic        clock,      // system clock
  input  wire logic        nrst,       // sync reset, low active
  input  wire logic        load,       // restart with loadCycles
  input  wire logic [11:0] loadCycles, // first interval length
  input  wire logic        run,        // cycle counting on
  input  wire logic        armEdge,    // preload edge counter
  input  wire logic        edgeMode,   // count falling edges
  input  wire logic        fallEdge,   // falling edge of receive pin
  output logic             tick,       // overflow pulse
  output logic             startSeen,  // edge counter wrapped
  output logic [7:0]       edgeCount   // edge counter value
);
  logic [11:0] count;

  // cycle counter; reloads a full bit after each overflow
  always_ff @(posedge clock) begin
    if (!nrst) begin
      count <= 12'h000;
      tick  <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (load) begin
        count <= loadCycles - 12'h001;
      end else if (run) begin
        if (count == 12'h000) begin
          tick  <= 1'b1;
          count <= hds_pkg::BIT_CYCLES - 12'h001;
        end else begin
          count <= count - 12'h001;
        end
      end
    end
  end

  // edge counter, no prescale; wrap from the preload marks a start bit
  always_ff @(posedge clock) begin
    if (!nrst) begin
      edgeCount <= hds_pkg::EDGE_PRELOAD;
      startSeen <= 1'b0;
    end else begin
      startSeen <= 1'b0;
      if (armEdge) begin
        edgeCount <= hds_pkg::EDGE_PRELOAD;
      end else if (edgeMode && fallEdge) begin
        edgeCount <= edgeCount + 8'h01;
        startSeen <= (edgeCount == hds_pkg::EDGE_PRELOAD);
      end
    end
  end
endmodule
`default_nettype wire

/* File: verilog/hds_uart.sv */
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - bit period derived from clock and bit rate; each bit leaves on one tick.
// - armed receiver counts receive pin falling edges from preload 0xFF.
// - edge counter wrap to 0x00 is taken as the start bit.
// - receive_request puts the port into reception, waiting for a start bit.
// - finished frame goes to rx_holding and clears rx_pending bit 3.
// - with parity on, transmitter sends computed parity after the data bits.
// - with parity on, receiver sets parity_fault bit 4 on mismatch.
// - parity sense odd or even, ignored while parity is off.
// - data_width configurable from 1 through 8.
// - exactly one stop bit, stop_count fixed at one.
// - optional RTS/CTS handshake on two pins, none when off.
// - status bit 0 is 1 while transmitting, 0 once line is free.
// - tx_allow bit 1 set by send_request; clearing it aborts a transmission.
// - rx_active bit 2 set on start edge detection, cleared when byte complete or on false start.
// - framing_fault bit 5 set on a framing error.
// - ninth_bit bit 7 holds sent or received parity bit.
// - receive_request sets rx_pending until whole frame incl. stop is received.
// - tx_active clears after the stop bit is fully sent, or when tx_allow is cleared.
module hds_uart (
  input  wire logic        clock,        // 20 MHz system clock
  input  wire logic        nrst,         // sync reset, low active
  input  wire logic [7:0]  s_axi_awaddr,  // write address
  input  wire logic        s_axi_awvalid, // write address valid
  output logic             s_axi_awready, // write address ready
  input  wire logic [31:0] s_axi_wdata,   // write data
  input  wire logic [3:0]  s_axi_wstrb,   // write byte strobes
  input  wire logic        s_axi_wvalid,  // write data valid
  output logic             s_axi_wready,  // write data ready
  output logic [1:0]       s_axi_bresp,   // write response
  output logic             s_axi_bvalid,  // write response valid
  input  wire logic        s_axi_bready,  // write response ready
  input  wire logic [7:0]  s_axi_araddr,  // read address
  input  wire logic        s_axi_arvalid, // read address valid
  output logic             s_axi_arready, // read address ready
  output logic [31:0]      s_axi_rdata,   // read data
  output logic [1:0]       s_axi_rresp,   // read response
  output logic             s_axi_rvalid,  // read data valid
  input  wire logic        s_axi_rready,  // read data ready
  input  wire logic        receive_pin,   // serial in
  output logic             transmit_pin,  // serial out
  input  wire logic        ctsN,          // clear to send, low active
  output logic             rtsN           // request to send, low active
);
  hds_pkg::hds_state_e state;
  logic [7:0]  awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0]  wStrbQ;
  logic        awHeld;
  logic        wHeld;
  logic        wrEn;
  logic [7:0]  tx_holding;
  logic [7:0]  rx_holding;
  logic [7:0]  rxShift;
  logic [3:0]  data_width;
  logic        parityOn;
  logic        oddSense;
  logic        flow_control_on;
  logic        tx_active;
  logic        tx_allow;
  logic        rx_active;
  logic        rx_pending;
  logic        parity_fault;
  logic        framing_fault;
  logic        ninth_bit;
  logic [3:0]  bitIdx;
  logic [3:0]  lastIdx;
  logic        rxLevel;
  logic        rxLevelQ;
  logic        ctsLevel;
  logic        fallEdge;
  logic        tick;
  logic        startSeen;
  logic [7:0]  edgeCount;
  logic        timerLoad;
  logic [11:0] timerCycles;
  logic        sendReq;
  logic        receiveReq;
  logic        sendGo;
  logic        receiveGo;
  logic        rxDone;
  logic        falseStart;
  logic        stateWrite;
  logic [7:0]  rxWord;

  // pin synchronisers
  hds_sync u_rx_sync (
    .clock (clock),
    .nrst  (nrst),
    .pin   (receive_pin),
    .level (rxLevel)
  );
  hds_sync u_cts_sync (
    .clock (clock),
    .nrst  (nrst),
    .pin   (ctsN),
    .level (ctsLevel)
  );

  // falling edge on the filtered receive level
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rxLevelQ <= 1'b1;
    end else begin
      rxLevelQ <= rxLevel;
    end
  end
  assign fallEdge = rxLevelQ & ~rxLevel;

  hds_bit_timer u_timer (
    .clock      (clock),
    .nrst       (nrst),
    .load       (timerLoad),
    .loadCycles (timerCycles),
    .run        ((state == hds_pkg::S_TX) || (state == hds_pkg::S_RX)),
    .armEdge    (receiveGo || falseStart),
    .edgeMode   (state == hds_pkg::S_ARM),
    .fallEdge   (fallEdge),
    .tick       (tick),
    .startSeen  (startSeen),
    .edgeCount  (edgeCount)
  );

  // index of the stop bit within a frame
  assign lastIdx = data_width + {3'b000, parityOn} + 4'h1;

  // bus write decode and command pulses; commands outside idle are dropped
  assign wrEn       = awHeld && wHeld && !s_axi_bvalid;
  assign stateWrite = wrEn && (awAddrQ == hds_pkg::ADDR_STATE) && wStrbQ[0];
  assign sendReq    = wrEn && (awAddrQ == hds_pkg::ADDR_COMMAND) && wStrbQ[0]
                      && wDataQ[hds_pkg::CMD_SEND];
  assign receiveReq = wrEn && (awAddrQ == hds_pkg::ADDR_COMMAND) && wStrbQ[0]
                      && wDataQ[hds_pkg::CMD_RECEIVE];
  assign sendGo     = sendReq && (state == hds_pkg::S_IDLE);
  assign receiveGo  = receiveReq && !sendReq && (state == hds_pkg::S_IDLE);
  assign rxDone     = (state == hds_pkg::S_RX) && tick && (bitIdx == lastIdx);
  assign falseStart = (state == hds_pkg::S_RX) && tick && (bitIdx == 4'h0) && rxLevel;
  assign rxWord     = 8'({rxShift} >> (4'd8 - data_width));

  // timer restarts: full bit for sending, half bit to reach start centre
  assign timerLoad   = (state == hds_pkg::S_CTS && (!flow_control_on || !ctsLevel))
                       || startSeen;
  assign timerCycles = startSeen ? hds_pkg::HALF_CYCLES : hds_pkg::BIT_CYCLES;

  // AXI4-Lite write channels, taken in either order
  always_ff @(posedge clock) begin
    if (!nrst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= hds_pkg::RESP_OKAY;
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      awAddrQ       <= 8'h00;
      wDataQ        <= hds_pkg::WORD_ZERO;
      wStrbQ        <= 4'h0;
    end else begin
      s_axi_awready <= s_axi_awvalid && !s_axi_awready && !awHeld;
      s_axi_wready  <= s_axi_wvalid && !s_axi_wready && !wHeld;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld  <= 1'b1;
        awAddrQ <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld  <= 1'b1;
        wDataQ <= s_axi_wdata;
        wStrbQ <= s_axi_wstrb;
      end
      if (wrEn) begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddrQ == hds_pkg::ADDR_STATE || awAddrQ == hds_pkg::ADDR_TXHOLD
                         || awAddrQ == hds_pkg::ADDR_COMMAND
                         || awAddrQ == hds_pkg::ADDR_CONFIG
                         || awAddrQ == hds_pkg::ADDR_RXHOLD)
                        ? hds_pkg::RESP_OKAY : hds_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel, one cycle after the address
  always_ff @(posedge clock) begin
    if (!nrst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= hds_pkg::WORD_ZERO;
      s_axi_rresp   <= hds_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= hds_pkg::RESP_OKAY;
        case (s_axi_araddr)
          hds_pkg::ADDR_STATE:   s_axi_rdata <= {24'h00_0000, ninth_bit, 1'b0, framing_fault,
                                                 parity_fault, rx_pending, rx_active,
                                                 tx_allow, tx_active};
          hds_pkg::ADDR_TXHOLD:  s_axi_rdata <= {24'h00_0000, tx_holding};
          hds_pkg::ADDR_RXHOLD:  s_axi_rdata <= {24'h00_0000, rx_holding};
          hds_pkg::ADDR_COMMAND: s_axi_rdata <= hds_pkg::WORD_ZERO;
          hds_pkg::ADDR_CONFIG:  s_axi_rdata <= {22'h0_0000, hds_pkg::STOP_COUNT, 1'b0,
                                                 flow_control_on, oddSense, parityOn,
                                                 data_width};
          default: begin
            s_axi_rdata <= hds_pkg::WORD_ZERO;
            s_axi_rresp <= hds_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // configuration and transmit holding; widths outside 1..8 are ignored
  always_ff @(posedge clock) begin
    if (!nrst) begin
      data_width      <= hds_pkg::WIDTH_RESET;
      parityOn        <= 1'b0;
      oddSense        <= 1'b0;
      flow_control_on <= 1'b0;
      tx_holding      <= hds_pkg::BYTE_RESET;
    end else if (wrEn && wStrbQ[0]) begin
      if (awAddrQ == hds_pkg::ADDR_CONFIG) begin
        if (wDataQ[3:0] >= 4'h1 && wDataQ[3:0] <= 4'h8) begin
          data_width <= wDataQ[3:0];
        end
        parityOn        <= wDataQ[hds_pkg::CFG_PARITY_ON];
        oddSense        <= wDataQ[hds_pkg::CFG_ODD];
        flow_control_on <= wDataQ[hds_pkg::CFG_FLOW];
      end
      if (awAddrQ == hds_pkg::ADDR_TXHOLD && state == hds_pkg::S_IDLE) begin
        tx_holding <= wDataQ[7:0];
      end
    end
  end

  // port sequencing
  always_ff @(posedge clock) begin
    if (!nrst) begin
      state        <= hds_pkg::S_IDLE;
      bitIdx       <= 4'h0;
      transmit_pin <= 1'b1;
      rxShift      <= hds_pkg::BYTE_RESET;
    end else begin
      case (state)
        hds_pkg::S_IDLE: begin
          transmit_pin <= 1'b1;
          bitIdx       <= 4'h0;
          if (sendGo) begin
            state <= hds_pkg::S_CTS;
          end else if (receiveGo) begin
            state <= hds_pkg::S_ARM;
          end
        end
        hds_pkg::S_CTS: begin
          if (!tx_allow) begin
            state <= hds_pkg::S_IDLE;
          end else if (timerLoad) begin
            state <= hds_pkg::S_TX;
          end
        end
        hds_pkg::S_TX: begin
          if (!tx_allow) begin
            state        <= hds_pkg::S_IDLE;
            transmit_pin <= 1'b1;
          end else if (tick) begin
            bitIdx <= bitIdx + 4'h1;
            if (bitIdx > lastIdx) begin
              state <= hds_pkg::S_IDLE;
            end else if (bitIdx == 4'h0) begin
              transmit_pin <= 1'b0;
            end else if (bitIdx <= data_width) begin
              transmit_pin <= tx_holding[3'(bitIdx - 4'h1)];
            end else if (parityOn && bitIdx == data_width + 4'h1) begin
              transmit_pin <= ninth_bit;
            end else begin
              transmit_pin <= 1'b1;
            end
          end
        end
        hds_pkg::S_ARM: begin
          bitIdx <= 4'h0;
          if (startSeen) begin
            state <= hds_pkg::S_RX;
          end
        end
        hds_pkg::S_RX: begin
          if (falseStart) begin
            state <= hds_pkg::S_ARM;
          end else if (tick) begin
            bitIdx <= bitIdx + 4'h1;
            if (bitIdx >= 4'h1 && bitIdx <= data_width) begin
              rxShift <= {rxLevel, rxShift[7:1]};
            end
            if (rxDone) begin
              state <= hds_pkg::S_IDLE;
            end
          end
        end
        default: begin
          state <= hds_pkg::S_IDLE;
        end
      endcase
    end
  end

  // handshake out: ready to take data while waiting or receiving
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rtsN <= 1'b1;
    end else begin
      rtsN <= !(flow_control_on && (state == hds_pkg::S_ARM || state == hds_pkg::S_RX));
    end
  end

  // transmit flags
  always_ff @(posedge clock) begin
    if (!nrst) begin
      tx_allow  <= 1'b0;
      tx_active <= 1'b0;
    end else begin
      if (sendGo) begin
        tx_allow <= 1'b1;
      end else if (stateWrite) begin
        tx_allow <= wDataQ[hds_pkg::ST_TX_ALLOW];
      end
      if (sendGo) begin
        tx_active <= 1'b1;
      end else if (!tx_allow || (state == hds_pkg::S_TX && tick && bitIdx > lastIdx)) begin
        tx_active <= 1'b0;
      end
    end
  end

  // receive flags, holding register and ninth bit
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rx_pending    <= 1'b0;
      rx_active     <= 1'b0;
      parity_fault  <= 1'b0;
      framing_fault <= 1'b0;
      ninth_bit     <= 1'b0;
      rx_holding    <= hds_pkg::BYTE_RESET;
    end else begin
      if (receiveGo) begin
        rx_pending <= 1'b1;
      end else if (rxDone) begin
        rx_pending <= 1'b0;
      end
      if (startSeen) begin
        rx_active <= 1'b1;
      end else if (rxDone || falseStart) begin
        rx_active <= 1'b0;
      end
      if (sendGo) begin
        ninth_bit <= hds_pkg::hds_parity(tx_holding, data_width, oddSense);
      end else if (state == hds_pkg::S_RX && tick && parityOn
                   && bitIdx == data_width + 4'h1) begin
        ninth_bit <= rxLevel;
      end
      if (rxDone) begin
        rx_holding <= rxWord;
      end
      // hardware result wins over a clear in the same cycle
      if (rxDone) begin
        parity_fault <= parityOn
                        && (hds_pkg::hds_parity(rxWord, data_width, oddSense) != ninth_bit);
      end else if (stateWrite && wDataQ[hds_pkg::ST_PARITY]) begin
        parity_fault <= 1'b0;
      end
      if (rxDone) begin
        framing_fault <= !rxLevel;
      end else if (stateWrite && wDataQ[hds_pkg::ST_FRAMING]) begin
        framing_fault <= 1'b0;
      end
    end
  end

  AST_IDLE_HIGH: assert property (@(posedge clock) disable iff (!nrst)
    (state == hds_pkg::S_IDLE) |=> transmit_pin)
    else $error("line not high while idle");
  AST_START_LOW: assert property (@(posedge clock) disable iff (!nrst)
    (state == hds_pkg::S_TX && tx_allow && tick && bitIdx == 4'h0) |=> !transmit_pin)
    else $error("start bit not low");
  AST_PRELOAD: assert property (@(posedge clock) disable iff (!nrst)
    receiveGo |=> (edgeCount == 8'hFF) && (state == hds_pkg::S_ARM))
    else $error("edge counter not preloaded");
  AST_PENDING: assert property (@(posedge clock) disable iff (!nrst)
    receiveGo |=> rx_pending && !rx_active)
    else $error("rx_pending not set by receive request");
  AST_RX_DONE: assert property (@(posedge clock) disable iff (!nrst)
    rxDone |=> !rx_pending && !rx_active && (rx_holding == $past(rxWord)))
    else $error("completion did not update holding and flags");
  AST_FRAMING: assert property (@(posedge clock) disable iff (!nrst)
    (rxDone && !rxLevel) |=> framing_fault)
    else $error("framing fault not recorded");
  AST_ABORT: assert property (@(posedge clock) disable iff (!nrst)
    (tx_active && !tx_allow && !sendGo) |=> !tx_active && transmit_pin)
    else $error("abort did not stop transmission");
  AST_TX_END: assert property (@(posedge clock) disable iff (!nrst)
    $fell(tx_active) |-> !$past(tx_allow) || ($past(tick) && $past(bitIdx) > $past(lastIdx)))
    else $error("tx_active fell before stop bit end");
  AST_START_ACT: assert property (@(posedge clock) disable iff (!nrst)
    startSeen |=> rx_active && (state == hds_pkg::S_RX))
    else $error("start detection did not set rx_active");
  AST_WIDTH: assert property (@(posedge clock) disable iff (!nrst)
    (data_width >= 4'h1) && (data_width <= 4'h8))
    else $error("data width out of range");
endmodule
`default_nettype wire

/* File: verilog/hds_uart_end.sv */
`default_nettype none
`default_nettype wire

/* File: test/hds_host.sv */
`timescale 1ns/1ps
`default_nettype none
module hds_host (
  input  wire logic        clock,        // system clock
  input  wire logic        transmit_pin, // device serial out
  output var  logic        receive_pin,  // device serial in
  output var  logic        ctsN,         // clear to send, low active
  output var  logic [10:0] frame         // last frame sampled
);
  localparam int BT = int'(hds_pkg::BIT_CYCLES);
  // line idles high, host always allows sending
  initial begin
    receive_pin = 1'b1;
    ctsN = 1'b0;
    frame = '0;
  end
  // sample mid bit, start through stop; stalls until the next start
  always begin
    @(negedge transmit_pin);
    repeat (BT / 2) @(posedge clock);
    for (int i = 0; i < 11; i++) begin
      frame[i] = transmit_pin;
      repeat (BT) @(posedge clock);
    end
  end
  // low start, data lsb first, parity, stop, back to idle
  task automatic host_send(input logic [7:0] d, input int n, input logic p, input logic s);
    for (int i = 0; i < n + 3; i++) begin
      @(posedge clock);
      receive_pin <= (i == 0) ? 1'b0 : (i <= n) ? d[i-1] : (i == n + 1) ? p : s;
      repeat (BT - 1) @(posedge clock);
    end
    @(posedge clock);
    receive_pin <= 1'b1;
  endtask
endmodule
`default_nettype wire

/* File: test/hds_uart_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module hds_uart_tb;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  s_axi_awaddr = '0;
  logic [7:0]  s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        transmit_pin, receive_pin, ctsN, rtsN;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, rd;
  logic [10:0] frame;
  int          err_total = 0;
  int          n_tests = 0;

  always #25 clock = ~clock;

  hds_uart i_dut (.clock, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .receive_pin, .transmit_pin, .ctsN, .rtsN);
  hds_host i_host (.clock, .transmit_pin, .receive_pin, .ctsN, .frame);

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // a wait that runs out ends the run
  task automatic hang(input int n);
    if (n >= 100) begin
      err_total++;
      $display("MISMATCH t=%0t no answer", $time);
      final_report();
    end
  endtask
  // each channel released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (!s_axi_bvalid && n < 100);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    hang(n);
  endtask
  task automatic rdr(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (!s_axi_rvalid && n < 100);
    rd = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    hang(n);
  endtask
  // status polling, bounded by frame length
  task automatic poll(input int b);
    int n;
    n = 0;
    do begin
      rdr(hds_pkg::ADDR_STATE);
      n++;
    end while (rd[b] !== 1'b0 && n < 8000);
    hang((rd[b] !== 1'b0) ? 100 : 0);
  endtask

  initial begin
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    rdr(hds_pkg::ADDR_STATE);
    chk(rd, 32'h0000_0000);
    rdr(hds_pkg::ADDR_CONFIG);
    chk(rd, 32'h0000_0108);
    rdr(8'h14);
    chk(32'(r), 32'h0000_0002);
    wr(8'h14, 32'h0000_0001);
    chk(32'(r), 32'h0000_0002);
    chk(32'(rtsN), 32'h0000_0001);
    // port is free, so fill then send, parity even
    wr(hds_pkg::ADDR_CONFIG, 32'h0000_0018);
    chk(32'(r), 32'h0000_0000);
    wr(hds_pkg::ADDR_TXHOLD, 32'h0000_00A7);
    wr(hds_pkg::ADDR_COMMAND, 32'h0000_0001);
    rdr(hds_pkg::ADDR_STATE);
    chk(rd, 32'h0000_0083);
    poll(0);
    chk(32'(frame), 32'h0000_074E);
    // five odd-parity bits, handshake on, with bad parity and low stop
    wr(hds_pkg::ADDR_CONFIG, 32'h0000_0075);
    wr(hds_pkg::ADDR_COMMAND, 32'h0000_0002);
    rdr(hds_pkg::ADDR_STATE);
    chk(rd & 32'h0000_000F, 32'h0000_000A);
    chk(32'(rtsN), 32'h0000_0000);
    fork
      i_host.host_send(8'h16, 5, 1'b1, 1'b0);
    join_none
    repeat (6000) @(posedge clock);
    rdr(hds_pkg::ADDR_STATE);
    chk(rd & 32'h0000_000C, 32'h0000_000C);
    poll(3);
    chk(rd, 32'h0000_00B2);
    chk(32'(rtsN), 32'h0000_0001);
    rdr(hds_pkg::ADDR_RXHOLD);
    chk(rd, 32'h0000_0016);
    chk(32'(r), 32'h0000_0000);
    wr(hds_pkg::ADDR_STATE, 32'h0000_0032);
    rdr(hds_pkg::ADDR_STATE);
    chk(rd, 32'h0000_0082);
    // drop the transmit allow in mid start bit
    wr(hds_pkg::ADDR_TXHOLD, 32'h0000_0055);
    wr(hds_pkg::ADDR_COMMAND, 32'h0000_0001);
    repeat (3000) @(posedge clock);
    wr(hds_pkg::ADDR_STATE, 32'h0000_0000);
    rdr(hds_pkg::ADDR_STATE);
    chk(rd & 32'h0000_0001, 32'h0000_0000);
    chk(32'(transmit_pin), 32'h0000_0001);
    final_report();
  end
endmodule
`default_nettype wire
